// ==== ftrim_consts.svh ====
`ifndef FTRIM_CONSTS_SVH
`define FTRIM_CONSTS_SVH

`define FTRIM_ADDR_USE        8'h00
`define FTRIM_ADDR_EU         8'h04
`define FTRIM_ADDR_FB_MAX     8'h08
`define FTRIM_ADDR_FB_PPR     8'h0c
`define FTRIM_ADDR_LEAD_MAX   8'h10
`define FTRIM_ADDR_LEAD_PPR   8'h14
`define FTRIM_ADDR_ZERO       8'h18
`define FTRIM_ADDR_GAIN       8'h1c
`define FTRIM_ADDR_SIGN       8'h20
`define FTRIM_ADDR_SETP       8'h24
`define FTRIM_ADDR_ADJ        8'h28
`define FTRIM_ADDR_REF        8'h2c
`define FTRIM_ADDR_FB_RPM     8'h30

`define FTRIM_USE_OFFSET      8'h03
`define FTRIM_SIGN_ADD        2'h1
`define FTRIM_SIGN_SUB        2'h2

`define FTRIM_RST_USE         8'h00
`define FTRIM_RST_EU          16'h03e8
`define FTRIM_RST_FB_MAX      16'h07d0
`define FTRIM_RST_FB_PPR      16'h003c
`define FTRIM_RST_LEAD_MAX    16'h07d0
`define FTRIM_RST_LEAD_PPR    16'h003c
`define FTRIM_RST_ZERO        11'h000
`define FTRIM_RST_GAIN        11'h3e8
`define FTRIM_RST_SIGN        2'h1
`define FTRIM_RST_SETP        16'h03e8

`define FTRIM_PCT_FS          64'd1000
`define FTRIM_OFS_DIV         64'd100000
`define FTRIM_RPM10_PER_PPS   64'd600

`endif

// ==== ftrim_pkg.sv ====
`default_nettype none
package ftrim_pkg;

   typedef struct packed {
      logic [7:0]  analog_input_use;
      logic [15:0] follower_eu_scale;
      logic [15:0] feedback_max_speed;
      logic [15:0] feedback_pulses_per_rev;
      logic [15:0] lead_max_speed;
      logic [15:0] lead_pulses_per_rev;
      logic [10:0] offset_zero_level;
      logic [10:0] offset_gain_percent;
      logic [1:0]  offset_sign_select;
      logic [15:0] follower_setpoint;
   } ftrim_cfg_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr_en;
      logic        rd_en;
   } ftrim_bus_req_t;

endpackage : ftrim_pkg
`default_nettype wire

// ==== ftrim_follower_offset.sv ====
// Summary of operation
// - Analog use value 3 selects offset operation.
// - Reference equals ratio reference plus/minus offset.
// - Offset is zero when input equals null.
// - Null is percent of analog full scale.
// - Full-range offset equals authority of feedback max.
// - Polarity 1: above null raises speed.
// - Polarity 2: above null lowers speed.
// - Engineering units mean ratio at both maxima.
// - Feedback pulses per rev converts feedback rate.
// - Lead pulses per rev and lead maximum scale.
// - Feedback maximum is full scale and authority base.
// - Settings reset to their documented defaults.
`timescale 1ns/1ps
`default_nettype none
`include "ftrim_consts.svh"

module ftrim_follower_offset #(
   parameter int ADC_W  = 12,
   parameter int RATE_W = 20
) (
   input  wire logic                  clock,
   input  wire logic                  srst,
   input  wire ftrim_pkg::ftrim_bus_req_t bus_req,
   output logic        [31:0]         rdata,
   input  wire logic                  control_tick,
   input  wire logic   [ADC_W-1:0]    analog_sample,
   input  wire logic   [RATE_W-1:0]   lead_pulse_rate,
   input  wire logic   [RATE_W-1:0]   feedback_pulse_rate,
   output logic        [31:0]         speed_ref,
   output logic                       speed_ref_valid,
   output logic        [31:0]         feedback_speed,
   output logic        [10:0]         analog_adjusted_reading
);

   // Rates wider than 22 bits would overflow the 64-bit ratio product at full settings.
   if (ADC_W < 8 || ADC_W > 16 || RATE_W < 8 || RATE_W > 20) begin : g_bad_width
      $error("ftrim_follower_offset: unsupported ADC_W or RATE_W");
   end

   localparam logic [63:0] ADC_FS = 64'((64'd1 << ADC_W) - 64'd1);

   ftrim_pkg::ftrim_cfg_t cfg_ff;
   ftrim_pkg::ftrim_cfg_t nxt_cfg;
   logic [31:0]           rdata_ff;
   logic [31:0]           nxt_rdata;
   logic [31:0]           ref_ff;
   logic [31:0]           nxt_ref;
   logic                  ref_valid_ff;
   logic [31:0]           fb_rpm_ff;
   logic [31:0]           nxt_fb_rpm;
   logic [10:0]           adj_ff;

   wire logic [7:0]  addr   = bus_req.addr;
   wire logic [31:0] wdata  = bus_req.wdata;
   wire logic        wr     = bus_req.wr_en;
   wire logic        sign_ok = (wdata[1:0] == `FTRIM_SIGN_ADD) || (wdata[1:0] == `FTRIM_SIGN_SUB);

   // Register writes; a polarity code other than add or subtract is ignored.
   always_comb begin
      nxt_cfg = cfg_ff;
      if (wr) begin
         unique case (addr)
            `FTRIM_ADDR_USE:      nxt_cfg.analog_input_use        = wdata[7:0];
            `FTRIM_ADDR_EU:       nxt_cfg.follower_eu_scale       = wdata[15:0];
            `FTRIM_ADDR_FB_MAX:   nxt_cfg.feedback_max_speed      = wdata[15:0];
            `FTRIM_ADDR_FB_PPR:   nxt_cfg.feedback_pulses_per_rev = wdata[15:0];
            `FTRIM_ADDR_LEAD_MAX: nxt_cfg.lead_max_speed          = wdata[15:0];
            `FTRIM_ADDR_LEAD_PPR: nxt_cfg.lead_pulses_per_rev     = wdata[15:0];
            `FTRIM_ADDR_ZERO:     nxt_cfg.offset_zero_level       = wdata[10:0];
            `FTRIM_ADDR_GAIN:     nxt_cfg.offset_gain_percent     = wdata[10:0];
            `FTRIM_ADDR_SIGN:     nxt_cfg.offset_sign_select      = sign_ok ? wdata[1:0]
                                                                : cfg_ff.offset_sign_select;
            `FTRIM_ADDR_SETP:     nxt_cfg.follower_setpoint       = wdata[15:0];
            default:              nxt_cfg = cfg_ff;
         endcase
      end
   end

   always_comb begin
      unique case (addr)
         `FTRIM_ADDR_USE:      nxt_rdata = {24'h000000, cfg_ff.analog_input_use};
         `FTRIM_ADDR_EU:       nxt_rdata = {16'h0000, cfg_ff.follower_eu_scale};
         `FTRIM_ADDR_FB_MAX:   nxt_rdata = {16'h0000, cfg_ff.feedback_max_speed};
         `FTRIM_ADDR_FB_PPR:   nxt_rdata = {16'h0000, cfg_ff.feedback_pulses_per_rev};
         `FTRIM_ADDR_LEAD_MAX: nxt_rdata = {16'h0000, cfg_ff.lead_max_speed};
         `FTRIM_ADDR_LEAD_PPR: nxt_rdata = {16'h0000, cfg_ff.lead_pulses_per_rev};
         `FTRIM_ADDR_ZERO:     nxt_rdata = {21'h000000, cfg_ff.offset_zero_level};
         `FTRIM_ADDR_GAIN:     nxt_rdata = {21'h000000, cfg_ff.offset_gain_percent};
         `FTRIM_ADDR_SIGN:     nxt_rdata = {30'h00000000, cfg_ff.offset_sign_select};
         `FTRIM_ADDR_SETP:     nxt_rdata = {16'h0000, cfg_ff.follower_setpoint};
         `FTRIM_ADDR_ADJ:      nxt_rdata = {21'h000000, adj_ff};
         `FTRIM_ADDR_REF:      nxt_rdata = ref_ff;
         `FTRIM_ADDR_FB_RPM:   nxt_rdata = fb_rpm_ff;
         default:              nxt_rdata = 32'h00000000;
      endcase
   end

   // Input level in tenths of a percent of analog full scale.
   wire logic [63:0] adj_wide = (64'(analog_sample) * `FTRIM_PCT_FS) / ADC_FS;
   wire logic [10:0] nxt_adj  = adj_wide[10:0];

   // Ratio reference in tenths of rpm; a zero divisor yields a zero reference.
   wire logic [63:0] base_num = 64'(lead_pulse_rate) * `FTRIM_RPM10_PER_PPS
                              * 64'(cfg_ff.feedback_max_speed)
                              * 64'(cfg_ff.follower_setpoint);
   wire logic [63:0] base_den = 64'(cfg_ff.lead_pulses_per_rev)
                              * 64'(cfg_ff.lead_max_speed)
                              * 64'(cfg_ff.follower_eu_scale);
   wire logic [63:0] base_q   = (base_den == 64'd0) ? 64'd0 : base_num / base_den;
   wire logic [31:0] base_ref = (base_q[63:32] != 32'h00000000) ? 32'hffffffff : base_q[31:0];

   wire logic [63:0] fb_q     = (cfg_ff.feedback_pulses_per_rev == 16'h0000) ? 64'd0
                              : (64'(feedback_pulse_rate) * `FTRIM_RPM10_PER_PPS)
                                / 64'(cfg_ff.feedback_pulses_per_rev);

   // Offset magnitude: |input - null| times authority times feedback maximum.
   wire logic        above    = adj_ff > cfg_ff.offset_zero_level;
   wire logic [10:0] diff_mag = above ? adj_ff - cfg_ff.offset_zero_level
                              : cfg_ff.offset_zero_level - adj_ff;
   wire logic [63:0] ofs_q    = (64'(diff_mag) * 64'(cfg_ff.offset_gain_percent)
                              * 64'(cfg_ff.feedback_max_speed)) / `FTRIM_OFS_DIV;
   wire logic [31:0] ofs_mag  = ofs_q[31:0];
   wire logic        offset_mode = cfg_ff.analog_input_use == `FTRIM_USE_OFFSET;
   wire logic        raise    = above ^ (cfg_ff.offset_sign_select == `FTRIM_SIGN_SUB);
   wire logic [32:0] sum_ref  = {1'b0, base_ref} + {1'b0, ofs_mag};
   wire logic [31:0] up_ref   = sum_ref[32] ? 32'hffffffff : sum_ref[31:0];
   wire logic [31:0] dn_ref   = (base_ref > ofs_mag) ? base_ref - ofs_mag : 32'h00000000;

   // Speed cannot go negative, so a large subtraction clamps at zero.
   assign nxt_ref    = !offset_mode ? base_ref : (raise ? up_ref : dn_ref);
   assign nxt_fb_rpm = fb_q[31:0];

   always_ff @(posedge clock) begin
      if (srst) begin
         cfg_ff <= '{`FTRIM_RST_USE, `FTRIM_RST_EU, `FTRIM_RST_FB_MAX, `FTRIM_RST_FB_PPR,
                     `FTRIM_RST_LEAD_MAX, `FTRIM_RST_LEAD_PPR, `FTRIM_RST_ZERO,
                     `FTRIM_RST_GAIN, `FTRIM_RST_SIGN, `FTRIM_RST_SETP};
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= bus_req.rd_en ? nxt_rdata : 32'h00000000;
      end
   end

   // The adjusted reading is latched on the tick, so offset follows one tick behind input.
   always_ff @(posedge clock) begin
      if (srst) begin
         adj_ff       <= 11'h000;
         ref_ff       <= 32'h00000000;
         fb_rpm_ff    <= 32'h00000000;
         ref_valid_ff <= 1'b0;
      end else begin
         ref_valid_ff <= control_tick;
         if (control_tick) begin
            adj_ff    <= nxt_adj;
            ref_ff    <= nxt_ref;
            fb_rpm_ff <= nxt_fb_rpm;
         end
      end
   end

   assign rdata                   = rdata_ff;
   assign speed_ref               = ref_ff;
   assign speed_ref_valid         = ref_valid_ff;
   assign feedback_speed          = fb_rpm_ff;
   assign analog_adjusted_reading = adj_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_offset_tick;
      control_tick && offset_mode;
   endsequence

   sequence s_ratio_tick;
      control_tick && !offset_mode;
   endsequence

   a_tick_latency: assert property (control_tick |=> speed_ref_valid && speed_ref == $past(nxt_ref))
      else $error("reference not updated one cycle after tick");

   a_hold_between: assert property (!control_tick |=> $stable(speed_ref) && !speed_ref_valid)
      else $error("reference moved without a tick");

   a_mode_gate: assert property (s_ratio_tick |=> speed_ref == $past(base_ref))
      else $error("offset applied outside offset mode");

   a_null_zero: assert property (s_offset_tick ##0 (adj_ff == cfg_ff.offset_zero_level)
                                 |=> speed_ref == $past(base_ref))
      else $error("nonzero offset at null level");

   a_polarity_add: assert property (s_offset_tick ##0 (above && cfg_ff.offset_sign_select
                                    == `FTRIM_SIGN_ADD) |=> speed_ref >= $past(base_ref))
      else $error("additive offset lowered speed above null");

   a_polarity_sub: assert property (s_offset_tick ##0 (above && cfg_ff.offset_sign_select
                                    == `FTRIM_SIGN_SUB) |=> speed_ref <= $past(base_ref))
      else $error("subtractive offset raised speed above null");

   a_full_scale: assert property (s_offset_tick ##0 (diff_mag == 11'd1000)
                                  |-> 64'(ofs_mag) == (64'(cfg_ff.offset_gain_percent)
                                  * 64'(cfg_ff.feedback_max_speed)) / 64'd100)
      else $error("full range offset differs from authority");

   a_adj_read: assert property (bus_req.rd_en && addr == `FTRIM_ADDR_ADJ
                                |=> rdata == {21'h000000, $past(adj_ff)})
      else $error("adjusted reading not returned");

   a_reset_values: assert property (disable iff (1'b0) srst |=> cfg_ff.offset_gain_percent
                                    == `FTRIM_RST_GAIN && cfg_ff.analog_input_use
                                    == `FTRIM_RST_USE && cfg_ff.offset_sign_select
                                    == `FTRIM_RST_SIGN)
      else $error("settings not at defaults after reset");

   // The checks below reuse these steps of an update.
   sequence s_raise_tick;
      s_offset_tick ##0 raise;
   endsequence

   sequence s_lower_tick;
      s_offset_tick ##0 !raise;
   endsequence

   // Equal scale and maxima at the default lead PPR make the ratio part ten times the rate.
   sequence s_unity_scale;
      cfg_ff.follower_eu_scale == cfg_ff.follower_setpoint
      && cfg_ff.lead_max_speed == cfg_ff.feedback_max_speed
      && cfg_ff.lead_pulses_per_rev == `FTRIM_RST_LEAD_PPR;
   endsequence

   // Saturation is left out here, since a clamped sum no longer equals the true sum.
   a_raise_sum: assert property (s_raise_tick ##0 !sum_ref[32]
                                 |=> 33'(speed_ref) == 33'($past(base_ref)) + 33'($past(ofs_mag)))
      else $error("raised reference is not base plus offset");

   a_lower_diff: assert property (s_lower_tick ##0 (base_ref > ofs_mag)
                                  |=> speed_ref == $past(base_ref) - $past(ofs_mag))
      else $error("lowered reference is not base minus offset");

   // A trim larger than the base stops the follower rather than reversing it.
   a_lower_clamp: assert property (s_lower_tick ##0 (base_ref <= ofs_mag)
                                   |=> speed_ref == 32'h00000000)
      else $error("lowered reference did not clamp at zero");

   a_adj_range: assert property (speed_ref_valid |-> analog_adjusted_reading <= 11'h3e8)
      else $error("adjusted reading beyond full scale");

   // Both ends of the input range map onto the ends of the percent scale.
   a_adj_ends: assert property (control_tick && analog_sample == '1
                                |=> analog_adjusted_reading == 11'h3e8)
      else $error("full scale input not read as full scale");

   a_adj_floor: assert property (control_tick && analog_sample == '0
                                 |=> analog_adjusted_reading == 11'h000)
      else $error("zero input not read as zero");

   // Sixty pulses a revolution make the feedback speed exactly ten times the pulse rate.
   a_fb_default: assert property (control_tick
                                  && cfg_ff.feedback_pulses_per_rev == `FTRIM_RST_FB_PPR
                                  |=> 64'(feedback_speed)
                                      == 64'($past(feedback_pulse_rate)) * 64'h000000000000000a)
      else $error("feedback speed not ten times the rate at default PPR");

   a_unity_ratio: assert property (s_ratio_tick ##0 s_unity_scale
                                   |=> 64'(speed_ref)
                                       == 64'($past(lead_pulse_rate)) * 64'h000000000000000a)
      else $error("ratio reference not scaled by units and maxima");

   // The offset can never pass its full-range value while both levels stay in range.
   a_ofs_bound: assert property (s_offset_tick ##0 (adj_ff <= 11'h3e8)
                                 ##0 (cfg_ff.offset_zero_level <= 11'h3e8)
                                 |-> 64'(ofs_mag) * 64'h0000000000000064
                                     <= 64'(cfg_ff.offset_gain_percent)
                                        * 64'(cfg_ff.feedback_max_speed))
      else $error("offset exceeds authority of feedback maximum");

   // Refused polarity writes must leave a legal code behind.
   a_sign_legal: assert property (cfg_ff.offset_sign_select == `FTRIM_SIGN_ADD
                                  || cfg_ff.offset_sign_select == `FTRIM_SIGN_SUB)
      else $error("polarity holds an illegal code");

   // A lone tick gives a lone valid pulse, so downstream logic never takes one update twice.
   a_valid_pulse: assert property (speed_ref_valid && !control_tick |=> !speed_ref_valid)
      else $error("valid stood longer than one update");

   a_reset_outputs: assert property (disable iff (1'b0) srst
                                     |=> speed_ref == 32'h00000000 && !speed_ref_valid
                                     && rdata == 32'h00000000)
      else $error("outputs not cleared by reset");

endmodule : ftrim_follower_offset
`default_nettype wire

// ==== ftrim_field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Stands for the pulse sensors, the dancer pot and the control scheduler.
// Levels change only just after an edge, so each tick samples settled values.
module ftrim_field_model #(
   parameter int ADC_W  = 12,
   parameter int RATE_W = 20
) (
   input  wire logic                clock,
   output var logic                 control_tick,
   output var logic [ADC_W-1:0]     analog_sample,
   output var logic [RATE_W-1:0]    lead_pulse_rate,
   output var logic [RATE_W-1:0]    feedback_pulse_rate
);
   initial begin
      control_tick = 1'b0;
      analog_sample = '0;
      lead_pulse_rate = '0;
      feedback_pulse_rate = '0;
   end

   task automatic set_field(input logic [ADC_W-1:0] a, input logic [RATE_W-1:0] l,
                            input logic [RATE_W-1:0] f);
      @(posedge clock);
      analog_sample <= a;
      lead_pulse_rate <= l;
      feedback_pulse_rate <= f;
   endtask : set_field

   task automatic update();
      @(posedge clock);
      control_tick <= 1'b1;
      @(posedge clock);
      control_tick <= 1'b0;
   endtask : update
endmodule : ftrim_field_model
`default_nettype wire

// ==== follower_offset_trim_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ftrim_consts.svh"
module follower_offset_trim_bench;
   logic                      clock = 1'b0;
   logic                      srst = 1'b1;
   ftrim_pkg::ftrim_bus_req_t bus_req = '0;
   logic [31:0]               rdata;
   logic                      control_tick;
   logic [11:0]               analog_sample;
   logic [19:0]               lead_pulse_rate;
   logic [19:0]               feedback_pulse_rate;
   logic [31:0]               speed_ref;
   logic                      speed_ref_valid;
   logic [31:0]               feedback_speed;
   logic [10:0]               analog_adjusted_reading;
   int                        fails = 0;
   int                        check_count = 0;

   always #5 clock = ~clock;

   ftrim_follower_offset #(.ADC_W(12), .RATE_W(20)) ftrim_follower_offset_inst (
      .clock(clock), .srst(srst), .bus_req(bus_req), .rdata(rdata),
      .control_tick(control_tick), .analog_sample(analog_sample),
      .lead_pulse_rate(lead_pulse_rate), .feedback_pulse_rate(feedback_pulse_rate),
      .speed_ref(speed_ref), .speed_ref_valid(speed_ref_valid),
      .feedback_speed(feedback_speed), .analog_adjusted_reading(analog_adjusted_reading));

   ftrim_field_model #(.ADC_W(12), .RATE_W(20)) ftrim_field_model_inst (
      .clock(clock), .control_tick(control_tick), .analog_sample(analog_sample),
      .lead_pulse_rate(lead_pulse_rate), .feedback_pulse_rate(feedback_pulse_rate));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr_en: 1'b1, rd_en: 1'b0};
      @(posedge clock);
      bus_req.wr_en <= 1'b0;
   endtask : wr

   // Read data is taken only in the one cycle where the block presents it.
   task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: 32'h0, wr_en: 1'b0, rd_en: 1'b1};
      @(posedge clock);
      bus_req.rd_en <= 1'b0;
      #1 chk(name, exp, rdata);
   endtask : rchk

   task automatic tick_chk(input logic [31:0] exp_ref);
      ftrim_field_model_inst.update();
      #1 chk("speed_ref_valid", 32'h1, {31'h0, speed_ref_valid});
      chk("speed_ref", exp_ref, speed_ref);
      @(posedge clock);
      #1 chk("speed_ref_valid", 32'h0, {31'h0, speed_ref_valid});
   endtask : tick_chk

   task automatic t_defaults();
      logic [7:0]  adr [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                                8'h20, 8'h24};
      logic [31:0] dv [10] = '{32'h0, 32'h3e8, 32'h7d0, 32'h3c, 32'h7d0, 32'h3c, 32'h0,
                               32'h3e8, 32'h1, 32'h3e8};
      chk("speed_ref", 32'h0, speed_ref);
      for (int i = 0; i < 10; i++) begin
         rchk("setting", adr[i], dv[i]);
      end
      rchk("unmapped", 8'h3c, 32'h0);
   endtask : t_defaults

   // Analog use 0 leaves the pot out of the reference entirely.
   task automatic t_ratio();
      ftrim_field_model_inst.set_field(12'hfff, 20'h7d0, 20'h258);
      tick_chk(32'h4e20);
      tick_chk(32'h4e20);
      chk("feedback_speed", 32'h1770, feedback_speed);
      chk("adjusted", 32'h3e8, {21'h0, analog_adjusted_reading});
      chk("speed_ref", 32'h4e20, speed_ref);
   endtask : t_ratio

   task automatic t_offset();
      wr(`FTRIM_ADDR_USE, 32'h3);
      wr(`FTRIM_ADDR_ZERO, 32'h258);
      wr(`FTRIM_ADDR_GAIN, 32'h96);
      wr(`FTRIM_ADDR_SIGN, 32'h2);
      tick_chk(32'h4970);
      tick_chk(32'h4970);
      rchk("adjusted", 8'h28, 32'h3e8);
      ftrim_field_model_inst.set_field(12'h000, 20'h7d0, 20'h258);
      tick_chk(32'h4970);
      tick_chk(32'h5528);
      wr(`FTRIM_ADDR_SIGN, 32'h1);
      tick_chk(32'h4718);
      wr(`FTRIM_ADDR_SIGN, 32'h3);
      rchk("sign", 8'h20, 32'h1);
      ftrim_field_model_inst.set_field(12'h999, 20'h7d0, 20'h258);
      tick_chk(32'h4718);
      tick_chk(32'h4e20);
      chk("adjusted", 32'h258, {21'h0, analog_adjusted_reading});
   endtask : t_offset

   // The ratio part follows the newest lead rate while the pot term lags one tick.
   task automatic t_scale();
      wr(`FTRIM_ADDR_FB_MAX, 32'h3e8);
      ftrim_field_model_inst.set_field(12'hfff, 20'h3e8, 20'h258);
      tick_chk(32'h1388);
      tick_chk(32'h15e0);
      chk("feedback_speed", 32'h1770, feedback_speed);
      rchk("speed_ref", 8'h2c, 32'h15e0);
   endtask : t_scale

   // Scale settings away from their defaults, then full-range offset and a clamp at zero.
   task automatic t_units();
      wr(`FTRIM_ADDR_USE, 32'h0);
      wr(`FTRIM_ADDR_EU, 32'h7d0);
      tick_chk(32'h09c4);
      wr(`FTRIM_ADDR_LEAD_PPR, 32'h78);
      tick_chk(32'h04e2);
      wr(`FTRIM_ADDR_LEAD_MAX, 32'h3e8);
      tick_chk(32'h09c4);
      wr(`FTRIM_ADDR_FB_PPR, 32'h1e);
      tick_chk(32'h09c4);
      chk("feedback_speed", 32'h2ee0, feedback_speed);
      wr(`FTRIM_ADDR_USE, 32'h3);
      wr(`FTRIM_ADDR_ZERO, 32'h0);
      tick_chk(32'h0fa0);
      wr(`FTRIM_ADDR_GAIN, 32'h12c);
      tick_chk(32'h157c);
      wr(`FTRIM_ADDR_SIGN, 32'h2);
      tick_chk(32'h0);
   endtask : t_units

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (3000) @(posedge clock);
      fails++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      #1;
      t_defaults();
      t_ratio();
      t_offset();
      t_scale();
      t_units();
      summarize();
   end
endmodule : follower_offset_trim_bench
`default_nettype wire
